// file: rtl/eruc_consts.svh
// Purpose: offsets, field positions, reset values and timing counts of the enable/reset block
// Assumes: 40 MHz system clock, one 32-bit word per register
// Notes: included by bare name from the top, blanking and bench files
`ifndef ERUC_CONSTS_SVH
`define ERUC_CONSTS_SVH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define ERUC_CLK_PERIOD_NS 25
`define ERUC_UV_BLANK_NS 150000
// least time: round up to whole cycles
`define ERUC_UV_BLANK_CYC ((`ERUC_UV_BLANK_NS + `ERUC_CLK_PERIOD_NS - 1) / `ERUC_CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define ERUC_ADDR_W 8
`define ERUC_OFS_CTRL 8'h00
`define ERUC_OFS_STATUS 8'h04
`define ERUC_OFS_IRQ_STAT 8'h08
`define ERUC_OFS_IRQ_MASK 8'h0C
`define ERUC_OFS_SERIAL_RX 8'h10

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define ERUC_CTRL_HOLD_BIT 0
`define ERUC_CTRL_UV_LSB 1
`define ERUC_CTRL_UV_MSB 3
`define ERUC_CTRL_SET_LSB 4
`define ERUC_CTRL_SET_MSB 7
`define ERUC_CTRL_RST 8'h00
`define ERUC_UV_OFF 3'h0

// ----------------------------------------------------------------------
// interrupt bits
// ----------------------------------------------------------------------
`define ERUC_IRQ_W 4
`define ERUC_IRQ_RESET_IN 0
`define ERUC_IRQ_RESET_OUT 1
`define ERUC_IRQ_UV_TRIP 2
`define ERUC_IRQ_SERIAL 3
`define ERUC_IRQ_MASK_RST 4'h0

`endif

// file: rtl/eruc_pkg.sv
// Purpose: types shared by the enable/reset block
// Assumes: nothing beyond SystemVerilog packed types
// Notes: numeric constants live in eruc_consts.svh
package eruc_pkg;

   // ----------------------------------------------------------------------
   // sequencer states
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      ERUC_ST_RESET = 3'b001,
      ERUC_ST_POR_WAIT = 3'b010,
      ERUC_ST_RUN = 3'b100
   } eruc_state_t;

   // ----------------------------------------------------------------------
   // controls handed to the analog side
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic regulator_on;
      logic boost_enable;
      logic [3:0] gate_supply_setpoint;
      logic [2:0] gate_supply_uv_threshold;
   } eruc_analog_ctl_t;

   typedef struct packed {
      logic chip_select_low_pull_up;
      logic serial_data_in_pull_down;
      logic serial_clock_pull_down;
      logic boost_sync_input_pull_down;
      logic enable_input_one_pull_down;
      logic enable_input_two_failsafe_pull_down;
   } eruc_pull_ctl_t;

endpackage : eruc_pkg

// file: rtl/eruc_top.sv
// Purpose: enable, reset and gate-supply lockout sequencing of a boost LED driver
// Assumes: all pins already synchronous to clk_i; register port per house bus
// Notes: analog comparators arrive as plain levels; serial command set not decoded
`include "eruc_consts.svh"

// What this block does
// - stay in reset until an enable is high
// - hold-enable keeps regulator on without enables while in run state
// - hold low, enables low: enter reset
// - leave power-on wait for run only when both supplies good
// - undervoltage disables the boost stage
// - ignore undervoltage 150 us after reset release
// - 3-bit threshold, zero disables lockout
// - 4-bit setpoint selects gate supply level
// - everything runs from one internal clock
// - pull chip select up, others down
// - serial output drives low only
// - sample serial input on rising clock
module eruc_top #(
   parameter int unsigned UV_BLANK_CYCLES = `ERUC_UV_BLANK_CYC
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic enable_input_one_i,
   input wire logic enable_input_two_failsafe_i,
   input wire logic por_vdd_ok_i,
   input wire logic battery_supply_ok_i,
   input wire logic gate_drive_supply_low_i,
   input wire logic chip_select_low_i,
   input wire logic serial_clock_i,
   input wire logic serial_data_in_i,
   input wire logic [`ERUC_ADDR_W-1:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   output logic irq_o,
   output eruc_pkg::eruc_analog_ctl_t analog_ctl_o,
   output eruc_pkg::eruc_pull_ctl_t pull_ctl_o,
   output logic in_reset_o,
   output logic serial_data_out_o,
   output logic serial_data_out_oe_o
);
   import eruc_pkg::*;

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   function automatic logic hit(input logic [`ERUC_ADDR_W-1:0] a,
                                input logic [`ERUC_ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   // ----------------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------------
   // one clock domain: timings all derive from the single internal oscillator
   eruc_state_t state_ff;
   eruc_state_t nxt_state;
   logic por_release;
   logic any_enable;
   logic supplies_ok;
   logic [7:0] ctrl_ff;
   logic hold_en;

   assign any_enable = enable_input_one_i | enable_input_two_failsafe_i;
   assign supplies_ok = por_vdd_ok_i & battery_supply_ok_i;
   assign hold_en = ctrl_ff[`ERUC_CTRL_HOLD_BIT];

   always_comb begin
      nxt_state = state_ff;
      por_release = 1'b0;
      unique case (state_ff)
         ERUC_ST_RESET: begin
            if (any_enable) begin
               nxt_state = ERUC_ST_POR_WAIT;
            end
         end
         ERUC_ST_POR_WAIT: begin
            if (!any_enable) begin
               nxt_state = ERUC_ST_RESET;
            end else if (supplies_ok) begin
               nxt_state = ERUC_ST_RUN;
               por_release = 1'b1;
            end
         end
         ERUC_ST_RUN: begin
            if (!any_enable && !hold_en) begin
               nxt_state = ERUC_ST_RESET;
            end else if (!supplies_ok) begin
               nxt_state = ERUC_ST_POR_WAIT;
            end
            // hold-enable alone keeps the run state
         end
         default: begin
            nxt_state = ERUC_ST_RESET;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_ff <= ERUC_ST_RESET;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ----------------------------------------------------------------------
   // undervoltage lockout
   // ----------------------------------------------------------------------
   logic blanking;
   logic uv_lock;
   logic uv_lock_ff;
   logic [2:0] uv_thr;

   eruc_uv_blank #(
      .BLANK_CYCLES(UV_BLANK_CYCLES)
   ) u_blank (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .start_i(por_release),
      .blanking_o(blanking)
   );

   assign uv_thr = ctrl_ff[`ERUC_CTRL_UV_MSB:`ERUC_CTRL_UV_LSB];
   // threshold zero switches the detector off entirely
   assign uv_lock = gate_drive_supply_low_i && (uv_thr != `ERUC_UV_OFF) && !blanking;

   // ----------------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------------
   logic [7:0] nxt_ctrl;
   logic [`ERUC_IRQ_W-1:0] irq_stat_ff;
   logic [`ERUC_IRQ_W-1:0] nxt_irq_stat;
   logic [`ERUC_IRQ_W-1:0] irq_mask_ff;
   logic [`ERUC_IRQ_W-1:0] nxt_irq_mask;
   logic [`ERUC_IRQ_W-1:0] irq_evt;
   logic [7:0] serial_rx_ff;
   logic [7:0] status_byte;
   logic [31:0] nxt_rdata;
   logic serial_done;
   logic is_reset;

   assign is_reset = (state_ff == ERUC_ST_RESET);
   assign status_byte = {3'h0, blanking, uv_lock_ff, state_ff};

   always_comb begin
      irq_evt = '0;
      irq_evt[`ERUC_IRQ_RESET_IN] = !is_reset && (nxt_state == ERUC_ST_RESET);
      irq_evt[`ERUC_IRQ_RESET_OUT] = por_release;
      irq_evt[`ERUC_IRQ_UV_TRIP] = uv_lock && !uv_lock_ff;
      irq_evt[`ERUC_IRQ_SERIAL] = serial_done;
   end

   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_irq_mask = irq_mask_ff;
      if (is_reset) begin
         nxt_ctrl = `ERUC_CTRL_RST;
      end else if (reg_wr_i && hit(reg_addr_i, `ERUC_OFS_CTRL)) begin
         nxt_ctrl = reg_wdata_i[7:0];
      end
      if (reg_wr_i && hit(reg_addr_i, `ERUC_OFS_IRQ_MASK)) begin
         nxt_irq_mask = reg_wdata_i[`ERUC_IRQ_W-1:0];
      end
      // read clears, but an event in the same cycle survives
      nxt_irq_stat = irq_stat_ff;
      if (reg_rd_i && hit(reg_addr_i, `ERUC_OFS_IRQ_STAT)) begin
         nxt_irq_stat = '0;
      end
      nxt_irq_stat = nxt_irq_stat | irq_evt;
      nxt_rdata = 32'h0000_0000;
      if (reg_rd_i) begin
         if (hit(reg_addr_i, `ERUC_OFS_CTRL)) begin
            nxt_rdata = {24'h00_0000, ctrl_ff};
         end else if (hit(reg_addr_i, `ERUC_OFS_STATUS)) begin
            nxt_rdata = {24'h00_0000, status_byte};
         end else if (hit(reg_addr_i, `ERUC_OFS_IRQ_STAT)) begin
            nxt_rdata = {28'h000_0000, irq_stat_ff};
         end else if (hit(reg_addr_i, `ERUC_OFS_IRQ_MASK)) begin
            nxt_rdata = {28'h000_0000, irq_mask_ff};
         end else if (hit(reg_addr_i, `ERUC_OFS_SERIAL_RX)) begin
            nxt_rdata = {24'h00_0000, serial_rx_ff};
         end
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl_ff <= `ERUC_CTRL_RST;
         irq_stat_ff <= '0;
         irq_mask_ff <= `ERUC_IRQ_MASK_RST;
         reg_rdata_o <= 32'h0000_0000;
         irq_o <= 1'b0;
         uv_lock_ff <= 1'b0;
      end else begin
         ctrl_ff <= nxt_ctrl;
         irq_stat_ff <= nxt_irq_stat;
         irq_mask_ff <= nxt_irq_mask;
         reg_rdata_o <= nxt_rdata;
         irq_o <= |(nxt_irq_stat & nxt_irq_mask);
         uv_lock_ff <= uv_lock;
      end
   end

   // ----------------------------------------------------------------------
   // serial pins
   // ----------------------------------------------------------------------
   // only edges, byte shifting and capture here; command decoding belongs to the serial block
   logic sclk_q_ff;
   logic cs_q_ff;
   logic [7:0] rx_shift_ff;
   logic [7:0] nxt_rx_shift;
   logic [7:0] tx_shift_ff;
   logic [7:0] nxt_tx_shift;
   logic [7:0] nxt_serial_rx;
   logic sclk_rise;
   logic sclk_fall;
   logic nxt_sdo_oe;

   assign sclk_rise = serial_clock_i && !sclk_q_ff;
   assign sclk_fall = !serial_clock_i && sclk_q_ff;
   assign serial_done = chip_select_low_i && !cs_q_ff && !is_reset;

   always_comb begin
      nxt_rx_shift = rx_shift_ff;
      nxt_tx_shift = tx_shift_ff;
      nxt_serial_rx = serial_rx_ff;
      if (is_reset) begin
         nxt_rx_shift = 8'h00;
         nxt_tx_shift = 8'hFF;
         nxt_serial_rx = 8'h00;
      end else if (!chip_select_low_i && cs_q_ff) begin
         nxt_tx_shift = status_byte;
         nxt_rx_shift = 8'h00;
      end else if (!chip_select_low_i) begin
         if (sclk_rise) begin
            nxt_rx_shift = {rx_shift_ff[6:0], serial_data_in_i};
         end
         if (sclk_fall) begin
            nxt_tx_shift = {tx_shift_ff[6:0], 1'b1};
         end
      end else if (serial_done) begin
         nxt_serial_rx = rx_shift_ff;
      end
      // open drain: drive only when the bit is a zero
      nxt_sdo_oe = !chip_select_low_i && !nxt_tx_shift[7] && !is_reset;
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sclk_q_ff <= 1'b0;
         cs_q_ff <= 1'b1;
         rx_shift_ff <= 8'h00;
         tx_shift_ff <= 8'hFF;
         serial_rx_ff <= 8'h00;
         serial_data_out_oe_o <= 1'b0;
         serial_data_out_o <= 1'b0;
      end else begin
         sclk_q_ff <= serial_clock_i;
         cs_q_ff <= chip_select_low_i;
         rx_shift_ff <= nxt_rx_shift;
         tx_shift_ff <= nxt_tx_shift;
         serial_rx_ff <= nxt_serial_rx;
         serial_data_out_oe_o <= nxt_sdo_oe;
         serial_data_out_o <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // outputs to the analog side
   // ----------------------------------------------------------------------
   eruc_analog_ctl_t nxt_analog;
   eruc_pull_ctl_t nxt_pull;

   always_comb begin
      nxt_analog.regulator_on = (nxt_state != ERUC_ST_RESET);
      nxt_analog.boost_enable = (nxt_state == ERUC_ST_RUN) && !uv_lock;
      nxt_analog.gate_supply_setpoint = nxt_ctrl[`ERUC_CTRL_SET_MSB:`ERUC_CTRL_SET_LSB];
      nxt_analog.gate_supply_uv_threshold = nxt_ctrl[`ERUC_CTRL_UV_MSB:`ERUC_CTRL_UV_LSB];
      // weak pulls give idle levels on undriven pins: every pull always on
      nxt_pull = '1;
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         analog_ctl_o <= '0;
         pull_ctl_o <= '1;
         in_reset_o <= 1'b1;
      end else begin
         analog_ctl_o <= nxt_analog;
         pull_ctl_o <= nxt_pull;
         in_reset_o <= (nxt_state == ERUC_ST_RESET);
      end
   end

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   property p_stay_reset;
      is_reset && !any_enable |=> in_reset_o && !analog_ctl_o.regulator_on;
   endproperty
   a_stay_reset: assert property (p_stay_reset) else $error("left reset without enable");

   property p_hold_keeps;
      state_ff == ERUC_ST_RUN && hold_en && supplies_ok |=> state_ff == ERUC_ST_RUN
         ##0 analog_ctl_o.regulator_on;
   endproperty
   a_hold_keeps: assert property (p_hold_keeps) else $error("hold-enable did not keep run");

   property p_enter_reset;
      state_ff == ERUC_ST_RUN && !hold_en && !any_enable |=> is_reset ##0 in_reset_o;
   endproperty
   a_enter_reset: assert property (p_enter_reset) else $error("reset not entered");

   property p_por_gate;
      $rose(state_ff == ERUC_ST_RUN) |-> $past(supplies_ok);
   endproperty
   a_por_gate: assert property (p_por_gate) else $error("run entered with bad supply");

   property p_uv_off;
      uv_lock |=> !analog_ctl_o.boost_enable;
   endproperty
   a_uv_off: assert property (p_uv_off) else $error("boost on during lockout");

   property p_blank;
      por_release |=> blanking [*8];
   endproperty
   a_blank: assert property (p_blank) else $error("blanking too short");

   property p_thr_zero;
      uv_thr == `ERUC_UV_OFF |-> !uv_lock;
   endproperty
   a_thr_zero: assert property (p_thr_zero) else $error("lockout active at code zero");

   property p_setpoint;
      reg_wr_i && hit(reg_addr_i, `ERUC_OFS_CTRL) && !is_reset |=>
         analog_ctl_o.gate_supply_setpoint == $past(reg_wdata_i[7:4]);
   endproperty
   a_setpoint: assert property (p_setpoint) else $error("setpoint not applied");

   property p_sdo_low;
      serial_data_out_oe_o |-> !serial_data_out_o && !$past(chip_select_low_i);
   endproperty
   a_sdo_low: assert property (p_sdo_low) else $error("serial output drove high");

   property p_rx_rise;
      !chip_select_low_i && !is_reset && sclk_rise && !cs_q_ff |=>
         rx_shift_ff[0] == $past(serial_data_in_i);
   endproperty
   a_rx_rise: assert property (p_rx_rise) else $error("serial bit not sampled");

   property p_reset_defaults;
      is_reset |=> ctrl_ff == `ERUC_CTRL_RST && !analog_ctl_o.boost_enable;
   endproperty
   a_reset_defaults: assert property (p_reset_defaults) else $error("settings kept in reset");

   property p_pulls;
      pull_ctl_o.chip_select_low_pull_up && pull_ctl_o.enable_input_one_pull_down;
   endproperty
   a_pulls: assert property (p_pulls) else $error("pull control dropped");

endmodule : eruc_top

// file: rtl/eruc_uv_blank.sv
// Purpose: blanking window for the gate-supply undervoltage detector
// Assumes: start_i is a one-cycle pulse at each power-on-reset release
// Notes: a new start restarts the full window
`include "eruc_consts.svh"

module eruc_uv_blank #(
   parameter int unsigned BLANK_CYCLES = `ERUC_UV_BLANK_CYC,
   parameter int unsigned CNT_W = $clog2(BLANK_CYCLES + 1)
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic start_i,
   output logic blanking_o
);
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   logic blank_ff;
   logic nxt_blank;

   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_blank = blank_ff;
      if (start_i) begin
         nxt_cnt = CNT_W'(BLANK_CYCLES - 1);
         nxt_blank = 1'b1;
      end else if (cnt_ff != '0) begin
         nxt_cnt = cnt_ff - CNT_W'(1);
      end else begin
         nxt_blank = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_ff <= '0;
         blank_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         blank_ff <= nxt_blank;
      end
   end

   assign blanking_o = blank_ff;

endmodule : eruc_uv_blank

// file: tb/eruc_host_model.sv
// Purpose: controller model that drives the enable pins and the serial port
// Assumes: clk_i is the system clock; serial timing is counted in its cycles
// Notes: lines rest at their pull levels whenever the controller is not driving them
module eruc_host_model (
   input wire logic clk_i,
   input wire logic serial_data_out_oe_i,
   output logic en1_o,
   output logic en2_o,
   output logic csn_o,
   output logic sclk_o,
   output logic sdi_o,
   output logic sdo_line_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // open drain: the external pull-up gives the high level
   assign sdo_line_o = serial_data_out_oe_i ? 1'b0 : 1'b1;

   initial begin
      en1_o = 1'b0;
      en2_o = 1'b0;
      csn_o = 1'b1;
      sclk_o = 1'b0;
      sdi_o = 1'b0;
   end

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask : wait_cyc

   task automatic set_enables(input logic e1, input logic e2);
      @(posedge clk_i);
      en1_o <= e1;
      en2_o <= e2;
   endtask : set_enables

   // --------------------------------------------------------------
   // serial frame
   // --------------------------------------------------------------
   // slow phases of 20 cycles: wide margin over setup and hold
   task automatic send_byte(input logic [7:0] b);
      wait_cyc(1);
      csn_o <= 1'b0;
      for (int i = 7; i >= 0; i--) begin
         wait_cyc(10);
         sdi_o <= b[i];
         wait_cyc(10);
         sclk_o <= 1'b1;
         wait_cyc(20);
         sclk_o <= 1'b0;
      end
      // data released to the pull-down level once hold time is over
      wait_cyc(12);
      sdi_o <= 1'b0;
      wait_cyc(8);
      csn_o <= 1'b1;
      wait_cyc(40);
   endtask : send_byte

endmodule : eruc_host_model

// file: tb/eruc_top_bench.sv
// Purpose: self-checking bench for the enable, reset and lockout block
// Assumes: blanking shortened to 20 cycles through the top parameter
// Notes: register accesses use the one-cycle strobe port
`include "eruc_consts.svh"

`define ERUC_TB_CHK(got, exp) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) begin \
         bad_count++; \
         $display("BAD t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
      end \
   end

module eruc_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import eruc_pkg::*;

   localparam int unsigned BLANK = 20;

   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic por_ok = 1'b0;
   logic bat_ok = 1'b0;
   logic gate_low = 1'b0;
   logic [`ERUC_ADDR_W-1:0] addr = '0;
   logic [31:0] wdata = '0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic irq;
   eruc_analog_ctl_t actl;
   eruc_pull_ctl_t pulls;
   logic in_reset;
   logic serial_data_out;
   logic sdo_oe;
   logic en1, en2, csn, sclk, serial_data_in, sdo_line;
   int bad_count = 0;
   int comparisons = 0;

   initial begin
      forever #12.5 clk_i = ~clk_i;
   end

   eruc_host_model host_u (.clk_i(clk_i), .serial_data_out_oe_i(sdo_oe), .en1_o(en1),
      .en2_o(en2), .csn_o(csn), .sclk_o(sclk), .sdi_o(serial_data_in), .sdo_line_o(sdo_line));

   eruc_top #(.UV_BLANK_CYCLES(BLANK)) dut_u (.clk_i(clk_i), .resetn_i(resetn_i),
      .enable_input_one_i(en1), .enable_input_two_failsafe_i(en2), .por_vdd_ok_i(por_ok),
      .battery_supply_ok_i(bat_ok), .gate_drive_supply_low_i(gate_low),
      .chip_select_low_i(csn), .serial_clock_i(sclk), .serial_data_in_i(serial_data_in),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .irq_o(irq), .analog_ctl_o(actl), .pull_ctl_o(pulls),
      .in_reset_o(in_reset), .serial_data_out_o(serial_data_out), .serial_data_out_oe_o(sdo_oe));

   // --------------------------------------------------------------
   // bus tasks
   // --------------------------------------------------------------
   // cycles are counted then sampled 1 ns late so edge updates have landed
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : wait_cyc

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask : reg_wr

   task automatic reg_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge clk_i);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk_i);
      rd <= 1'b0;
      #1;
      `ERUC_TB_CHK(rdata & m, e)
   endtask : reg_chk

   task automatic summarize();
      if (bad_count == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : summarize

   // a hang is cut well past the roughly 500 cycles the tests need
   initial begin
      repeat (20000) @(posedge clk_i);
      bad_count++;
      summarize();
   end

   // --------------------------------------------------------------
   // tests
   // --------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk_i);
      resetn_i <= 1'b1;
      wait_cyc(3);
      `ERUC_TB_CHK({in_reset, actl.regulator_on, actl.boost_enable}, 3'b100)
      `ERUC_TB_CHK(pulls, 6'h3F)
      `ERUC_TB_CHK({serial_data_out, sdo_oe, sdo_line}, 3'b001)
      reg_wr(`ERUC_OFS_CTRL, 32'h0000_00A6);
      reg_chk(`ERUC_OFS_CTRL, 32'hFFFF_FFFF, 32'h0);
      reg_chk(8'h14, 32'hFFFF_FFFF, 32'h0);
      reg_chk(`ERUC_OFS_IRQ_MASK, 32'hFFFF_FFFF, 32'h0);
      reg_chk(`ERUC_OFS_STATUS, 32'h7, 32'h1);
      host_u.set_enables(1'b0, 1'b1);
      wait_cyc(3);
      `ERUC_TB_CHK({in_reset, actl.regulator_on}, 2'b01)
      por_ok <= 1'b1;
      wait_cyc(6);
      reg_chk(`ERUC_OFS_STATUS, 32'h7, 32'h2);
      reg_wr(`ERUC_OFS_CTRL, 32'h0000_00A6);
      reg_chk(`ERUC_OFS_CTRL, 32'hFFFF_FFFF, 32'hA6);
      `ERUC_TB_CHK({actl.gate_supply_setpoint, actl.gate_supply_uv_threshold}, 7'h53)
      gate_low <= 1'b1;
      bat_ok <= 1'b1;
      wait_cyc(4);
      `ERUC_TB_CHK(actl.boost_enable, 1'b1)
      reg_chk(`ERUC_OFS_STATUS, 32'h17, 32'h14);
      // release event is sticky: unmasking it afterwards must still raise the line
      reg_wr(`ERUC_OFS_IRQ_MASK, 32'h2);
      wait_cyc(2);
      `ERUC_TB_CHK(irq, 1'b1)
      reg_chk(`ERUC_OFS_IRQ_STAT, 32'h2, 32'h2);
      wait_cyc(2);
      `ERUC_TB_CHK(irq, 1'b0)
      wait_cyc(BLANK + 5);
      `ERUC_TB_CHK(actl.boost_enable, 1'b0)
      reg_wr(`ERUC_OFS_CTRL, 32'h0000_00A0);
      wait_cyc(3);
      `ERUC_TB_CHK(actl.boost_enable, 1'b1)
      gate_low <= 1'b0;
      bat_ok <= 1'b0;
      wait_cyc(3);
      `ERUC_TB_CHK(actl.boost_enable, 1'b0)
      reg_chk(`ERUC_OFS_STATUS, 32'h7, 32'h2);
      bat_ok <= 1'b1;
      host_u.send_byte(8'h5A);
      reg_chk(`ERUC_OFS_SERIAL_RX, 32'hFF, 32'h5A);
      `ERUC_TB_CHK({serial_data_out, sdo_oe, sdo_line}, 3'b001)
      reg_wr(`ERUC_OFS_CTRL, 32'h0000_0001);
      host_u.set_enables(1'b0, 1'b0);
      wait_cyc(10);
      `ERUC_TB_CHK({in_reset, actl.regulator_on}, 2'b01)
      // setpoint left non-zero so that only the reset default can clear it
      reg_wr(`ERUC_OFS_CTRL, 32'h0000_00F0);
      wait_cyc(3);
      `ERUC_TB_CHK({in_reset, actl.regulator_on, actl.boost_enable}, 3'b100)
      reg_chk(`ERUC_OFS_CTRL, 32'hFFFF_FFFF, 32'h0);
      `ERUC_TB_CHK(actl.gate_supply_setpoint, 4'h0)
      host_u.set_enables(1'b1, 1'b0);
      wait_cyc(3);
      `ERUC_TB_CHK({in_reset, actl.regulator_on}, 2'b01)
      summarize();
   end

endmodule : eruc_top_bench
